// ---- shared/sarpr_defines.svh ----
// Constants for the successive-approximation converter control and readout.
// Functional notes
// - Busy high exactly while converting.
// - Conversion steps follow the external conversion clock.
// - Read strobe gates result onto the bus.
// - Half select low: full word, MSB top.
// - Half select high: bits 15..8 on low lines.
// - Half select switches halves during one read.
// - Start on trigger fall with select low, sixteen rises.
// - Bus driven only with select and strobe low.
// - Results coded in straight binary.
`ifndef SARPR_DEFINES_SVH
`define SARPR_DEFINES_SVH

// ==========================================================
// Result format
`define SARPR_RESULT_W      16
`define SARPR_MIDSCALE      16'h8000
`define SARPR_RESULT_RST    16'h0000
`define SARPR_HALF_PAD      8'h00
`define SARPR_BUS_ON        16'hFFFF
`define SARPR_BUS_OFF       16'h0000

// ==========================================================
// Conversion stepping
`define SARPR_STEP_W        4
`define SARPR_STEP_FIRST    4'h0
`define SARPR_STEP_LAST     4'hF
`define SARPR_STEP_ONE      4'h1

// ==========================================================
// Result buffer
`define SARPR_FIFO_DEPTH    8

// ==========================================================
// Pin synchroniser lanes and their idle levels
`define SARPR_PIN_W         6
`define SARPR_PIN_IDLE      6'h07
`define SARPR_LANE_TRIG     0
`define SARPR_LANE_CS       1
`define SARPR_LANE_RD       2
`define SARPR_LANE_HALF     4
`define SARPR_LANE_CLK      5
`define SARPR_LANE_CMP      3

`endif

// ---- shared/sarpr_pkg.sv ----
// Types shared by the converter control and readout design.
package sarpr_pkg;

    // ==========================================================
    // Conversion sequencer states, Gray coded from IDLE to CONV to STORE; the return to IDLE flips both bits.
    typedef enum logic [1:0] {
        SARPR_IDLE  = 2'b00,
        SARPR_CONV  = 2'b01,
        SARPR_STORE = 2'b11
    } sarpr_state_e;

endpackage

// ---- logic/sarpr_sync.sv ----
// Two-stage synchroniser for a bank of pin inputs.
`timescale 1ns/1ps
module sarpr_sync #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stageOne_ff;
    logic [WIDTH-1:0] stageTwo_ff;

    // ==========================================================
    // The first stage feeds only the second one.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stageOne_ff <= RST_VAL;
            stageTwo_ff <= RST_VAL;
        end else begin
            stageOne_ff <= pinIn;
            stageTwo_ff <= stageOne_ff;
        end
    end

    assign pinSync = stageTwo_ff;

endmodule

// ---- logic/sarpr_fifo.sv ----
// Result buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sarpr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic             inVld,
    output logic                  inRdy,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outVld,
    input  wire logic             outRdy,
    output logic      [WIDTH-1:0] outData
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_ff;
    logic [PTR_W-1:0] nxt_wrPtr;
    logic [PTR_W-1:0] rdPtr_ff;
    logic [PTR_W-1:0] nxt_rdPtr;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             doPush;
    logic             doPop;

    assign inRdy   = (count_ff != CNT_W'(DEPTH));
    assign outVld  = (count_ff != '0);
    assign outData = mem[rdPtr_ff];
    assign doPush  = inVld & inRdy;
    assign doPop   = outVld & outRdy;

    // ==========================================================
    // Pointer and fill count.
    always_comb begin
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        nxt_count = count_ff;
        if (doPush) begin
            nxt_wrPtr = (wrPtr_ff == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_ff + PTR_W'(1);
        end
        if (doPop) begin
            nxt_rdPtr = (rdPtr_ff == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_ff + PTR_W'(1);
        end
        if (doPush && !doPop) begin
            nxt_count = count_ff + CNT_W'(1);
        end else if (doPop && !doPush) begin
            nxt_count = count_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end

    // Storage has no reset; words are only read while counted as valid.
    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_ff] <= inData;
        end
    end

endmodule

// ---- logic/sarpr_top.sv ----
// Conversion sequencer and parallel result readout of the converter.
`timescale 1ns/1ps
`include "sarpr_defines.svh"
module sarpr_top (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // Host control pins
    input  wire logic                        conversionTriggerN,
    input  wire logic                        chipSelN,
    input  wire logic                        readN,
    input  wire logic                        halfSel,
    // Conversion clock pin and comparator decision
    input  wire logic                        convClk,
    input  wire logic                        cmpAbove,
    // Status and trial code to the capacitor array
    output logic                             busy,
    output logic [`SARPR_RESULT_W-1:0]       dacTrial,
    // Three-state result bus
    output logic [`SARPR_RESULT_W-1:0]       resultBusOut,
    output logic [`SARPR_RESULT_W-1:0]       resultBusOe
);

    // ==========================================================
    // Pin synchronisation
    logic [`SARPR_PIN_W-1:0] pinRaw;
    logic [`SARPR_PIN_W-1:0] pinSync;
    logic                    trigS;
    logic                    csS;
    logic                    rdS;
    logic                    halfS;
    logic                    clkS;
    logic                    cmpS;

    assign pinRaw = {convClk, halfSel, cmpAbove, readN, chipSelN, conversionTriggerN};

    sarpr_sync #(
        .WIDTH   (`SARPR_PIN_W),
        .RST_VAL (`SARPR_PIN_IDLE)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pinIn   (pinRaw),
        .pinSync (pinSync)
    );

    assign trigS = pinSync[`SARPR_LANE_TRIG];
    assign csS   = pinSync[`SARPR_LANE_CS];
    assign rdS   = pinSync[`SARPR_LANE_RD];
    assign halfS = pinSync[`SARPR_LANE_HALF];
    assign clkS  = pinSync[`SARPR_LANE_CLK];
    assign cmpS  = pinSync[`SARPR_LANE_CMP];

    // ==========================================================
    // Edge detection on synchronised levels
    logic trigPrev_ff;
    logic clkPrev_ff;
    logic trigFall;
    logic clkRise;
    logic readActive;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trigPrev_ff <= 1'b1;
            clkPrev_ff  <= 1'b0;
        end else begin
            trigPrev_ff <= trigS;
            clkPrev_ff  <= clkS;
        end
    end

    assign trigFall   = trigPrev_ff & ~trigS;
    assign clkRise    = ~clkPrev_ff & clkS;
    assign readActive = ~csS & ~rdS;

    // ==========================================================
    // Conversion sequencer
    sarpr_pkg::sarpr_state_e           state_ff;
    sarpr_pkg::sarpr_state_e           nxt_state;
    logic [`SARPR_STEP_W-1:0]          step_ff;
    logic [`SARPR_STEP_W-1:0]          nxt_step;
    logic [`SARPR_RESULT_W-1:0]        trial_ff;
    logic [`SARPR_RESULT_W-1:0]        nxt_trial;
    logic [`SARPR_RESULT_W-1:0]        result_ff;
    logic [`SARPR_RESULT_W-1:0]        nxt_result;
    logic                              busy_ff;
    logic                              nxt_busy;
    logic [`SARPR_RESULT_W-1:0]        curMask;
    logic [`SARPR_RESULT_W-1:0]        decided;
    logic                              fifoInRdy;

    // The bit under test walks down from the top; each decision also raises the next trial bit.
    assign curMask = `SARPR_MIDSCALE >> step_ff;
    assign decided = (cmpS ? trial_ff : (trial_ff & ~curMask)) | (curMask >> 1);

    always_comb begin
        nxt_state  = state_ff;
        nxt_step   = step_ff;
        nxt_trial  = trial_ff;
        nxt_result = result_ff;
        case (state_ff)
            sarpr_pkg::SARPR_IDLE: begin
                if (trigFall && !csS) begin
                    nxt_state = sarpr_pkg::SARPR_CONV;
                    nxt_step  = `SARPR_STEP_FIRST;
                    nxt_trial = `SARPR_MIDSCALE;
                end
            end
            sarpr_pkg::SARPR_CONV: begin
                if (clkRise) begin
                    nxt_trial = decided;
                    if (step_ff == `SARPR_STEP_LAST) begin
                        nxt_state  = sarpr_pkg::SARPR_STORE;
                        nxt_result = decided;
                    end else begin
                        nxt_step = step_ff + `SARPR_STEP_ONE;
                    end
                end
            end
            sarpr_pkg::SARPR_STORE: begin
                // A full buffer holds the conversion open, so no result is lost at the buffer input.
                if (fifoInRdy) begin
                    nxt_state = sarpr_pkg::SARPR_IDLE;
                end
            end
            default: begin
                nxt_state = sarpr_pkg::SARPR_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != sarpr_pkg::SARPR_IDLE);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff  <= sarpr_pkg::SARPR_IDLE;
            step_ff   <= `SARPR_STEP_FIRST;
            trial_ff  <= `SARPR_RESULT_RST;
            result_ff <= `SARPR_RESULT_RST;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            step_ff   <= nxt_step;
            trial_ff  <= nxt_trial;
            result_ff <= nxt_result;
            busy_ff   <= nxt_busy;
        end
    end

    // ==========================================================
    // Result buffer and presented word
    logic                       fifoOutVld;
    logic                       fifoOutRdy;
    logic [`SARPR_RESULT_W-1:0] fifoOutData;
    logic [`SARPR_RESULT_W-1:0] shown_ff;
    logic [`SARPR_RESULT_W-1:0] nxt_shown;

    // The presented word only moves between reads, so one read never mixes two results.
    assign fifoOutRdy = ~readActive;

    sarpr_fifo #(
        .WIDTH (`SARPR_RESULT_W),
        .DEPTH (`SARPR_FIFO_DEPTH)
    ) u_fifo (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .inVld   (state_ff == sarpr_pkg::SARPR_STORE),
        .inRdy   (fifoInRdy),
        .inData  (result_ff),
        .outVld  (fifoOutVld),
        .outRdy  (fifoOutRdy),
        .outData (fifoOutData)
    );

    always_comb begin
        nxt_shown = shown_ff;
        if (fifoOutVld && fifoOutRdy) begin
            nxt_shown = fifoOutData;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shown_ff <= `SARPR_RESULT_RST;
        end else begin
            shown_ff <= nxt_shown;
        end
    end

    // ==========================================================
    // Output bus drive
    logic [`SARPR_RESULT_W-1:0] busOut_ff;
    logic [`SARPR_RESULT_W-1:0] nxt_busOut;
    logic [`SARPR_RESULT_W-1:0] busOe_ff;
    logic [`SARPR_RESULT_W-1:0] nxt_busOe;

    // Half select is followed every cycle, so it may toggle while the strobe stays low.
    always_comb begin
        nxt_busOe  = readActive ? `SARPR_BUS_ON : `SARPR_BUS_OFF;
        nxt_busOut = shown_ff;
        if (halfS) begin
            nxt_busOut = {`SARPR_HALF_PAD, shown_ff[15:8]};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busOut_ff <= `SARPR_RESULT_RST;
            busOe_ff  <= `SARPR_BUS_OFF;
        end else begin
            busOut_ff <= nxt_busOut;
            busOe_ff  <= nxt_busOe;
        end
    end

    assign busy         = busy_ff;
    assign dacTrial     = trial_ff;
    assign resultBusOut = busOut_ff;
    assign resultBusOe  = busOe_ff;

    // ==========================================================
    // Assertions
    // Checks speak of synchronised levels, two edges behind the pins.
    a_busy_state: assert property (@(posedge mclk) disable iff (sys_rst)
        busy_ff == (state_ff != sarpr_pkg::SARPR_IDLE))
        else $error("busy does not match conversion state");

    a_trigger_start: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_IDLE && trigFall && !csS) |=> busy_ff && trial_ff == `SARPR_MIDSCALE)
        else $error("trigger did not start a conversion");

    a_step_on_clock: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_CONV && !clkRise) |=> $stable(trial_ff) && $stable(step_ff))
        else $error("conversion advanced without a clock rise");

    a_step_count: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_CONV && clkRise && step_ff != `SARPR_STEP_LAST)
        |=> state_ff == sarpr_pkg::SARPR_CONV && step_ff == $past(step_ff) + `SARPR_STEP_ONE)
        else $error("step count did not advance by one");

    a_sixteen_done: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(state_ff == sarpr_pkg::SARPR_STORE) |-> $past(step_ff) == `SARPR_STEP_LAST)
        else $error("conversion ended before sixteen clock rises");

    a_lsb_decision: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_CONV && clkRise && step_ff == `SARPR_STEP_LAST)
        |=> result_ff[0] == $past(cmpS) && result_ff[15:1] == $past(trial_ff[15:1]))
        else $error("final decision not stored in straight binary");

    a_bus_enable: assert property (@(posedge mclk) disable iff (sys_rst)
        (!readActive) |=> resultBusOe == `SARPR_BUS_OFF)
        else $error("bus driven without select and strobe");

    a_bus_on: assert property (@(posedge mclk) disable iff (sys_rst)
        readActive [*2] |-> resultBusOe == `SARPR_BUS_ON)
        else $error("bus not driven during a read");

    a_full_word: assert property (@(posedge mclk) disable iff (sys_rst)
        (readActive && !halfS) |=> resultBusOut == $past(shown_ff))
        else $error("full word not presented");

    a_half_word: assert property (@(posedge mclk) disable iff (sys_rst)
        (readActive && halfS) |=> resultBusOut == {`SARPR_HALF_PAD, $past(shown_ff[15:8])})
        else $error("upper half not on the low lines");

    a_half_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
        (readActive && $changed(halfS)) |=> $changed(resultBusOut) || $past(shown_ff[15:8]) == $past(shown_ff[7:0])
            || $past(shown_ff) == `SARPR_RESULT_RST)
        else $error("half select change not followed within a read");

    a_busy_end: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(busy) |-> $past(state_ff) == sarpr_pkg::SARPR_STORE && $past(fifoInRdy))
        else $error("busy fell before the result was stored");

    a_store_wait: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_STORE && !fifoInRdy) |=> busy && state_ff == sarpr_pkg::SARPR_STORE)
        else $error("busy dropped while the buffer was full");

    a_select_needed: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_IDLE && trigFall && csS) |=> !busy)
        else $error("trigger without chip select started a conversion");

    a_idle_trial: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == sarpr_pkg::SARPR_IDLE && !(trigFall && !csS)) |=> $stable(trial_ff))
        else $error("trial code moved while idle");

    a_word_steady: assert property (@(posedge mclk) disable iff (sys_rst)
        readActive |=> $stable(shown_ff))
        else $error("presented word changed during a read");

    c_conversion: cover property (@(posedge mclk) disable iff (sys_rst)
        $rose(state_ff == sarpr_pkg::SARPR_STORE));
    c_half_read: cover property (@(posedge mclk) disable iff (sys_rst)
        readActive && !halfS ##[1:20] readActive && halfS);
    c_store_stall: cover property (@(posedge mclk) disable iff (sys_rst)
        state_ff == sarpr_pkg::SARPR_STORE && !fifoInRdy);
    c_ignored_trigger: cover property (@(posedge mclk) disable iff (sys_rst)
        state_ff == sarpr_pkg::SARPR_IDLE && trigFall && csS);
    c_busy_trigger: cover property (@(posedge mclk) disable iff (sys_rst)
        busy_ff && trigFall);

endmodule

// ---- test/sarpr_analog_model.sv ----
// Far-side model: conversion clock source and comparator of the analog core.
`timescale 1ns/1ps
module sarpr_analog_model (
    // Clock
    input  wire logic        mclk,
    // Control from the bench
    input  wire logic        run,
    input  wire logic [15:0] vinCode,
    // Trial code in, decision and conversion clock out
    input  wire logic [15:0] dacTrial,
    output logic             convClk,
    output logic             cmpAbove,
    output logic [4:0]       riseCount
);
    // ==========================================================
    // Conversion clock
    logic [1:0] phase;

    initial begin
        convClk = 1'b0;
        phase = 2'h0;
        riseCount = 5'h00;
    end

    // Four mclk high and four low, so every level is seen by the two-stage synchroniser.
    // The clock stands still low between frames, and the rise count restarts with each frame.
    always @(posedge mclk) begin
        if (!run) begin
            convClk <= 1'b0;
            phase <= 2'h0;
            riseCount <= 5'h00;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                convClk <= !convClk;
                if (!convClk) begin
                    riseCount <= riseCount + 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // Comparator
    // A straight binary input code makes the successive approximation settle on that code.
    assign cmpAbove = (vinCode >= dacTrial);
endmodule

// ---- test/sarpr_top_tb.sv ----
// Self-checking testbench of the converter control and readout.
`timescale 1ns/1ps
`include "sarpr_defines.svh"
`define SARPR_TB_CHK(act, exp) \
    begin \
        checkCount++; \
        if ((act) !== (exp)) begin \
            errors++; \
            $display("ERROR t=%0t got %h expected %h", $time, (act), (exp)); \
        end \
    end
module sarpr_top_tb;
    // ==========================================================
    // Signals
    logic                       mclk;
    logic                       sys_rst;
    logic                       trigN;
    logic                       csN;
    logic                       readN;
    logic                       halfSel;
    logic                       run;
    logic [15:0]                vin;
    logic                       convClk;
    logic                       cmpAbove;
    logic [4:0]                 riseCount;
    logic                       busy;
    logic [`SARPR_RESULT_W-1:0] dacTrial;
    logic [`SARPR_RESULT_W-1:0] busOut;
    logic [`SARPR_RESULT_W-1:0] busOe;
    int                         errors;
    int                         checkCount;

    sarpr_top dut (
        .mclk(mclk), .sys_rst(sys_rst), .conversionTriggerN(trigN), .chipSelN(csN),
        .readN(readN), .halfSel(halfSel), .convClk(convClk), .cmpAbove(cmpAbove),
        .busy(busy), .dacTrial(dacTrial), .resultBusOut(busOut), .resultBusOe(busOe)
    );

    sarpr_analog_model analog (
        .mclk(mclk), .run(run), .vinCode(vin), .dacTrial(dacTrial),
        .convClk(convClk), .cmpAbove(cmpAbove), .riseCount(riseCount)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    task automatic conclude;
        if (errors == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Drives the read pins, then allows the three to four cycle pin latency to pass.
    task automatic pins(input logic cs, input logic rd, input logic hs);
        @(posedge mclk);
        csN <= cs;
        readN <= rd;
        halfSel <= hs;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
    endtask

    // One conversion; glitch adds a trigger while busy, stall expects a full buffer.
    task automatic convert(input logic [15:0] code, input bit glitch, input bit stall);
        int n;
        @(posedge mclk);
        vin <= code;
        csN <= 1'b0;
        trigN <= 1'b0;
        run <= 1'b1;
        repeat (4) @(posedge mclk);
        trigN <= 1'b1;
        @(negedge mclk);
        `SARPR_TB_CHK(busy, 1'b1)
        if (glitch) begin
            repeat (40) @(posedge mclk);
            trigN <= 1'b0;
            repeat (4) @(posedge mclk);
            trigN <= 1'b1;
        end
        n = 0;
        while (n < 400 && busy !== 1'b0 && !(stall && riseCount == 5'h10)) begin
            @(negedge mclk);
            n++;
        end
        if (stall) begin
            @(posedge mclk);
            run <= 1'b0;
            repeat (20) @(posedge mclk);
            @(negedge mclk);
            `SARPR_TB_CHK(busy, 1'b1)
        end else begin
            `SARPR_TB_CHK(riseCount, 5'h10)
            `SARPR_TB_CHK(dacTrial, code)
            @(posedge mclk);
            run <= 1'b0;
        end
    endtask

    // Reads only after busy is low, in full word and in byte mode with the strobe held.
    task automatic read_word(input logic [15:0] exp);
        pins(1'b0, 1'b1, 1'b0);
        `SARPR_TB_CHK(busOe, 16'h0000)
        pins(1'b0, 1'b0, 1'b0);
        `SARPR_TB_CHK(busOe, 16'hFFFF)
        `SARPR_TB_CHK(busOut, exp)
        pins(1'b0, 1'b0, 1'b1);
        `SARPR_TB_CHK(busOut, {8'h00, exp[15:8]})
        `SARPR_TB_CHK(busOe, 16'hFFFF)
        pins(1'b0, 1'b0, 1'b0);
        `SARPR_TB_CHK(busOut, exp)
        pins(1'b1, 1'b0, 1'b0);
        `SARPR_TB_CHK(busOe, 16'h0000)
        pins(1'b1, 1'b1, 1'b0);
        `SARPR_TB_CHK(busOe, 16'h0000)
    endtask

    task automatic ignored_trigger;
        @(posedge mclk);
        csN <= 1'b1;
        trigN <= 1'b0;
        repeat (4) @(posedge mclk);
        trigN <= 1'b1;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        `SARPR_TB_CHK(busy, 1'b0)
    endtask

    // Results pile up during one long read until the buffer refuses, then drain on release.
    task automatic buffer_fill;
        int n;
        pins(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < `SARPR_FIFO_DEPTH; i++) begin
            convert(16'h1111 * i[15:0] + 16'h0101, 1'b0, 1'b0);
        end
        `SARPR_TB_CHK(busOut, 16'h1234)
        convert(16'hC3A5, 1'b0, 1'b1);
        pins(1'b1, 1'b1, 1'b0);
        n = 0;
        while (n < 40 && busy !== 1'b0) begin
            @(negedge mclk);
            n++;
        end
        `SARPR_TB_CHK(busy, 1'b0)
        repeat (20) @(posedge mclk);
        read_word(16'hC3A5);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] codes [5];
        codes = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'hA5C3};
        errors = 0;
        checkCount = 0;
        sys_rst = 1'b1;
        trigN = 1'b1;
        csN = 1'b1;
        readN = 1'b1;
        halfSel = 1'b0;
        run = 1'b0;
        vin = 16'h0000;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        `SARPR_TB_CHK(busy, 1'b0)
        `SARPR_TB_CHK(busOe, 16'h0000)
        read_word(16'h0000);
        ignored_trigger();
        foreach (codes[i]) begin
            convert(codes[i], 1'b0, 1'b0);
            read_word(codes[i]);
        end
        convert(16'h1234, 1'b1, 1'b0);
        read_word(16'h1234);
        buffer_fill();
        conclude();
    end

    // A conversion takes some 130 cycles; the whole run needs well under 4000.
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        conclude();
    end
endmodule
